// File: include/link_ctl_pkg.sv
/*
 Shared constants and types for the link path control and status block:
 register map, control bit positions, code word kinds, packet beats,
 per-lane framing statistics and lane sync thresholds.
 Assumes one core clock domain and a single AHB-Lite slave.
*/
`default_nettype none

package link_ctl_pkg;

   // lane and data widths
   localparam int LANES = 20;
   localparam int ERR_W = 4;
   localparam int DATA_W = 64;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   localparam int CTRL_W = 6;
   localparam int STS_W = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_LOCK = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_TX_PKTS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_RX_PKTS = 8'h10;

   // control register fields
   localparam int CTL_TX_EN = 0;
   localparam int CTL_SEND_LF = 1;
   localparam int CTL_SEND_RF = 2;
   localparam int CTL_SEND_IDLE = 3;
   localparam int CTL_RX_EN = 4;
   localparam int CTL_RESYNC = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

   // status register fields
   localparam int STS_LFAULT = 0;
   localparam int STS_TX_ACT = 1;
   localparam int STS_RX_ACT = 2;
   localparam int STS_RX_DEC = 3;

   // bus encodings
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;

   // sync header values that count as good
   localparam logic [1:0] SYNC_DATA = 2'h1;
   localparam logic [1:0] SYNC_CTRL = 2'h2;

   // lane lock and statistics window
   localparam logic [6:0] LOCK_RUN = 7'h40;
   localparam logic [3:0] WIN_LAST = 4'hE;
   localparam logic [ERR_W-1:0] ERR_MAX = 4'hF;
   localparam logic [ERR_W-1:0] LOSS_ERRS = 4'h8;

   typedef enum logic [1:0]
   {
      CW_IDLE = 2'b00,
      CW_DATA = 2'b01,
      CW_LFAULT = 2'b10,
      CW_RFAULT = 2'b11
   } code_kind_t;

   typedef enum logic
   {
      LS_TX_INIT = 1'b0,
      LS_READY = 1'b1
   } link_state_t;

   typedef struct packed
   {
      logic sop;
      logic eop;
      logic err;
      logic [DATA_W-1:0] data;
   } beat_t;

   typedef struct packed
   {
      code_kind_t kind;
      beat_t beat;
   } code_word_t;

   typedef struct packed
   {
      logic valid;
      logic [ERR_W-1:0] count;
   } lane_stat_t;

endpackage : link_ctl_pkg

`default_nettype wire

// File: hw/lane_sync_check.sv
/*
 One PCS lane: checks sync headers, keeps lane lock and reports the number
 of bad headers seen in each window as a count with a one-cycle valid.
 Assumes headers arrive from decode logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module lane_sync_check
(
   input wire logic hclk, // core clock
   input wire logic hresetn, // async reset, active low
   input wire logic clear, // resync request, level
   input wire logic hdr_valid, // header present this cycle
   input wire logic [1:0] hdr, // two sync header bits
   output link_ctl_pkg::lane_stat_t stat, // window error count and valid
   output logic locked // lane has found header lock
);
   import link_ctl_pkg::*;

   logic [6:0] run_r;
   logic [3:0] hdr_cnt_r;
   logic [ERR_W-1:0] err_acc_r;
   logic [ERR_W:0] err_sum;
   logic [ERR_W-1:0] err_sat;
   lane_stat_t stat_r;
   logic locked_r;
   logic bad;
   logic win_end;

   // a header is good only when its two bits differ
   assign bad = hdr_valid && !((hdr == SYNC_DATA) || (hdr == SYNC_CTRL));
   assign err_sum = {1'b0, err_acc_r} + {{ERR_W{1'b0}}, bad};
   assign err_sat = err_sum[ERR_W] ? ERR_MAX : err_sum[ERR_W-1:0];
   assign win_end = hdr_valid && (hdr_cnt_r == WIN_LAST);

   // window accumulation; the count saturates rather than wrapping
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hdr_cnt_r <= 4'h0;
         err_acc_r <= '0;
         stat_r <= '0;
      end
      else if (clear)
      begin
         hdr_cnt_r <= 4'h0;
         err_acc_r <= '0;
         stat_r <= '0;
      end
      else
      begin
         stat_r.valid <= win_end;
         stat_r.count <= win_end ? err_sat : stat_r.count;
         if (hdr_valid)
         begin
            hdr_cnt_r <= win_end ? 4'h0 : hdr_cnt_r + 4'h1;
            err_acc_r <= win_end ? '0 : err_sat;
         end
      end
   end

   // lock after a run of good headers, lose it on a bad window
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_r <= 7'h00;
         locked_r <= 1'b0;
      end
      else if (clear)
      begin
         run_r <= 7'h00;
         locked_r <= 1'b0;
      end
      else if (hdr_valid)
      begin
         run_r <= bad ? 7'h00 : ((run_r == LOCK_RUN) ? run_r : run_r + 7'h01);
         if (!bad && (run_r == LOCK_RUN - 7'h01))
            locked_r <= 1'b1;
         else if (win_end && (err_sat >= LOSS_ERRS))
            locked_r <= 1'b0;
      end
   end

   assign stat = stat_r;
   assign locked = locked_r;

endmodule : lane_sync_check

`default_nettype wire

// File: hw/link_path_control_status.sv
/*
 Control and status for a 100G link path: transmit enable and forced code
 words, transmit init status, receive enable and resync, and per-lane
 framing error statistics. Registers are reached over AHB-Lite.
 Assumes user logic, decode logic and the bus master all run on hclk.
*/
// Our own choices: the register offsets and the AHB-Lite slave port.
// Notes on behaviour
// - transmit enable high sends user packets; low sends only idle words.
// - transmit enable falling mid-packet lets that packet finish, then stops.
// - send-local-fault makes the transmitter emit only local fault words.
// - send-remote-fault makes the transmitter emit only remote fault words.
// - send-idle makes the transmitter emit only idle words.
// - local fault status is high exactly while in the transmit init state.
// - receive enable low finishes current packet, then stops decoding input.
// - receive disabled means no statistics and an idle receive packet bus.
// - resync high resets receive path and forces realignment; low runs normally.
// - each lane drives a four-bit count of sync header errors.
// - a lane count means something only while its valid strobe is high.
// - counts may update any cycle and are increments for external counters.
`timescale 1ns/10ps
`default_nettype none

module link_path_control_status
(
   input wire logic hclk, // core clock, 10 MHz
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic tx_in_valid, // user beat offered
   input wire link_ctl_pkg::beat_t tx_in, // user beat
   output logic tx_in_ready, // user beat taken
   output link_ctl_pkg::code_word_t tx_out, // code word to the line
   input wire logic [link_ctl_pkg::LANES-1:0][1:0] lane_hdr, // sync headers
   input wire logic [link_ctl_pkg::LANES-1:0] lane_hdr_valid, // header strobes
   input wire logic rx_in_valid, // decoded beat present
   input wire link_ctl_pkg::beat_t rx_in, // decoded beat
   output logic rx_out_valid, // receive packet bus valid
   output link_ctl_pkg::beat_t rx_out, // receive packet bus beat
   output link_ctl_pkg::lane_stat_t [link_ctl_pkg::LANES-1:0] lane_stat, // framing stats
   output logic tx_local_fault // transmit init state, level
);
   import link_ctl_pkg::*;

   // register index decode, shared by read and write paths
   function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [2:0] s;
      s = 3'h0;
      unique case (a)
         OFS_CTRL: s = 3'h1;
         OFS_STATUS: s = 3'h2;
         OFS_LOCK: s = 3'h3;
         OFS_TX_PKTS: s = 3'h4;
         OFS_RX_PKTS: s = 3'h5;
         default: s = 3'h0;
      endcase
      return s;
   endfunction : reg_sel

   logic [CTRL_W-1:0] ctrl_r;
   logic [CTRL_W-1:0] ctrl_nxt;
   logic dp_write_r;
   logic [ADDR_W-1:0] dp_addr_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_value;
   logic [2:0] rd_sel;
   logic addr_phase;
   logic wr_ctrl;

   link_state_t state_r;
   link_state_t state_nxt;
   logic [LANES-1:0] lane_locked;
   logic all_locked;

   logic tx_act_r;
   logic rx_act_r;
   code_word_t tx_out_r;
   beat_t rx_out_r;
   logic rx_out_valid_r;
   logic [CNT_W-1:0] tx_pkts_r;
   logic [CNT_W-1:0] rx_pkts_r;

   logic tx_en;
   logic send_lf;
   logic send_rf;
   logic send_idle;
   logic rx_en;
   logic resync;
   logic forced;
   logic tx_take;
   logic decode_en;
   logic rx_take;
   logic [STS_W-1:0] status;
   code_kind_t kind_nxt;

   // control fields
   assign tx_en = ctrl_r[CTL_TX_EN];
   assign send_lf = ctrl_r[CTL_SEND_LF];
   assign send_rf = ctrl_r[CTL_SEND_RF];
   assign send_idle = ctrl_r[CTL_SEND_IDLE];
   assign rx_en = ctrl_r[CTL_RX_EN];
   assign resync = ctrl_r[CTL_RESYNC];

   // bus decode: zero wait states, so every access completes in one data phase
   assign addr_phase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
   assign wr_ctrl = dp_write_r && (reg_sel(dp_addr_r) == 3'h1);
   assign ctrl_nxt = wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl_r;
   assign rd_sel = reg_sel(haddr[ADDR_W-1:0]);
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_r;

   // status word, all live state
   assign status[STS_LFAULT] = (state_r == LS_TX_INIT);
   assign status[STS_TX_ACT] = tx_act_r;
   assign status[STS_RX_ACT] = rx_act_r;
   assign status[STS_RX_DEC] = decode_en;

   // read mux takes ctrl_nxt so a read right behind a write sees the new value
   always_comb
   begin
      rd_value = 32'h0000_0000;
      unique case (rd_sel)
         3'h1: rd_value = {{(32-CTRL_W){1'b0}}, ctrl_nxt};
         3'h2: rd_value = {{(32-STS_W){1'b0}}, status};
         3'h3: rd_value = {{(32-LANES){1'b0}}, lane_locked};
         3'h4: rd_value = {{(32-CNT_W){1'b0}}, tx_pkts_r};
         3'h5: rd_value = {{(32-CNT_W){1'b0}}, rx_pkts_r};
         default: rd_value = 32'h0000_0000;
      endcase
   end

   // address phase capture and registered read data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_write_r <= 1'b0;
         dp_addr_r <= '0;
         hrdata_r <= 32'h0000_0000;
      end
      else
      begin
         dp_write_r <= addr_phase && hwrite && (hsize == HSIZE_WORD);
         if (addr_phase)
            dp_addr_r <= haddr[ADDR_W-1:0];
         if (addr_phase && !hwrite)
            hrdata_r <= rd_value;
      end
   end

   // control register; resync is a plain level that software sets and clears
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_r <= CTRL_RESET;
      else
         ctrl_r <= ctrl_nxt;
   end

   // per-lane header checkers; decoding is held off while receive is disabled and no packet is open
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++)
      begin : g_lane
         lane_sync_check u_lane
         (
            .hclk(hclk),
            .hresetn(hresetn),
            .clear(resync),
            .hdr_valid(lane_hdr_valid[gi] && decode_en),
            .hdr(lane_hdr[gi]),
            .stat(lane_stat[gi]),
            .locked(lane_locked[gi])
         );
      end
   endgenerate

   assign all_locked = &lane_locked;

   // link state: init until every lane holds lock, back to init on resync
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         LS_TX_INIT:
            if (all_locked && !resync)
               state_nxt = LS_READY;
         LS_READY:
            if (!all_locked || resync)
               state_nxt = LS_TX_INIT;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_r <= LS_TX_INIT;
      else
         state_r <= state_nxt;
   end

   assign tx_local_fault = (state_r == LS_TX_INIT);

   // transmit acceptance: a new packet needs enable, a started one may finish
   assign forced = send_lf || send_rf || send_idle;
   assign tx_in_ready = !forced && (tx_act_r || tx_en);
   assign tx_take = tx_in_valid && tx_in_ready;

   // forced words replace any traffic, highest priority first
   always_comb
   begin
      if (send_lf)
         kind_nxt = CW_LFAULT;
      else if (send_rf)
         kind_nxt = CW_RFAULT;
      else if (send_idle)
         kind_nxt = CW_IDLE;
      else if (tx_take)
         kind_nxt = CW_DATA;
      else
         kind_nxt = CW_IDLE;
   end

   // transmit word register and packet tracking; a forced word cuts a packet
   // short but keeps it open, so the remainder follows once forcing ends
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_out_r <= '0;
         tx_act_r <= 1'b0;
         tx_pkts_r <= '0;
      end
      else
      begin
         tx_out_r.kind <= kind_nxt;
         tx_out_r.beat <= tx_take ? tx_in : '0;
         if (tx_take && tx_in.eop)
            tx_act_r <= 1'b0;
         else if (tx_take && tx_in.sop)
            tx_act_r <= 1'b1;
         if (tx_take && tx_in.eop)
            tx_pkts_r <= tx_pkts_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign tx_out = tx_out_r;

   // receive gating: keep decoding only while enabled or a packet is open
   assign decode_en = rx_en || rx_act_r;
   assign rx_take = rx_in_valid && decode_en && (state_r == LS_READY) && !resync;

   // receive bus register; bus stays all zero while nothing is taken
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_out_r <= '0;
         rx_out_valid_r <= 1'b0;
         rx_act_r <= 1'b0;
         rx_pkts_r <= '0;
      end
      else if (resync)
      begin
         rx_out_r <= '0;
         rx_out_valid_r <= 1'b0;
         rx_act_r <= 1'b0;
      end
      else
      begin
         rx_out_valid_r <= rx_take;
         rx_out_r <= rx_take ? rx_in : '0;
         if (rx_take && rx_in.eop)
            rx_act_r <= 1'b0;
         else if (rx_take && rx_in.sop && !rx_act_r)
            rx_act_r <= 1'b1;
         if (rx_take && rx_in.eop)
            rx_pkts_r <= rx_pkts_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign rx_out_valid = rx_out_valid_r;
   assign rx_out = rx_out_r;

endmodule : link_path_control_status

`default_nettype wire

// File: bench/link_path_control_status_assertions.sv
/*
 Port checker for the link path control and status block.
 Assumes one clock domain and is bound to every instance of the top module.
*/
`timescale 1ns/10ps
`default_nettype none

module link_path_control_status_assertions
(
   input wire logic hclk, // core clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   input wire logic tx_in_valid, // user beat offered
   input wire link_ctl_pkg::beat_t tx_in, // user beat
   input wire logic tx_in_ready, // user beat taken
   input wire link_ctl_pkg::code_word_t tx_out, // line code word
   input wire logic rx_in_valid, // decoded beat present
   input wire link_ctl_pkg::beat_t rx_in, // decoded beat
   input wire logic rx_out_valid, // receive bus valid
   input wire link_ctl_pkg::beat_t rx_out, // receive bus beat
   input wire link_ctl_pkg::lane_stat_t [link_ctl_pkg::LANES-1:0] lane_stat, // stats
   input wire logic tx_local_fault // transmit init state
);
   import link_ctl_pkg::*;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic wr_p;
   logic [CTRL_W-1:0] ctl_s;

   // shadow of the control word, so forced-word checks need no hierarchy peeking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_p <= 1'b0;
         ctl_s <= CTRL_RESET;
      end
      else
      begin
         wr_p <= hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD
            && haddr[7:0] == OFS_CTRL;
         if (wr_p)
            ctl_s <= hwdata[CTRL_W-1:0];
      end
   end

   property p_tx_pass;
      tx_in_valid && tx_in_ready |=> tx_out.kind == CW_DATA && tx_out.beat == $past(tx_in);
   endproperty
   a_tx_pass: assert property (p_tx_pass) else $error("beat not sent");
   property p_lf;
      ctl_s[CTL_SEND_LF] |=> tx_out.kind == CW_LFAULT;
   endproperty
   a_lf: assert property (p_lf) else $error("local fault word missing");
   property p_rf;
      ctl_s[2:1] == 2'b10 |=> tx_out.kind == CW_RFAULT;
   endproperty
   a_rf: assert property (p_rf) else $error("remote fault word missing");
   property p_idle;
      ctl_s[3:1] == 3'b100 |=> tx_out.kind == CW_IDLE;
   endproperty
   a_idle: assert property (p_idle) else $error("idle word missing");
   property p_refuse;
      ctl_s[3:1] != 3'b000 |-> !tx_in_ready;
   endproperty
   a_refuse: assert property (p_refuse) else $error("beat taken while forcing");
   property p_rx_pass;
      rx_out_valid |-> $past(rx_in_valid) && rx_out == $past(rx_in);
   endproperty
   a_rx_pass: assert property (p_rx_pass) else $error("receive beat wrong");
   property p_rx_idle;
      !rx_out_valid |-> rx_out == '0;
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("receive bus not idle");
   property p_resync;
      ctl_s[CTL_RESYNC] |=> !rx_out_valid ##1 tx_local_fault;
   endproperty
   a_resync: assert property (p_resync) else $error("resync did not reset");
   property p_pulse;
      lane_stat[0].valid |=> !lane_stat[0].valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("stat valid too long");
endmodule : link_path_control_status_assertions

bind link_path_control_status link_path_control_status_assertions u_chk
(
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
   .tx_in_valid, .tx_in, .tx_in_ready, .tx_out, .rx_in_valid, .rx_in,
   .rx_out_valid, .rx_out, .lane_stat, .tx_local_fault
);

`default_nettype wire

// File: bench/link_partner_model.sv
/*
 Far-end partner model: streams sync headers on all PCS lanes.
 Assumes run and bad change just after a rising edge of hclk.
*/
`timescale 1ns/10ps
`default_nettype none

module link_partner_model
(
   input wire logic hclk, // core clock
   input wire logic run, // headers flow while high
   input wire logic bad, // lane 0 sends a broken header
   output logic [link_ctl_pkg::LANES-1:0][1:0] lane_hdr, // sync headers
   output logic [link_ctl_pkg::LANES-1:0] lane_hdr_valid // header strobes
);
   import link_ctl_pkg::*;

   // good headers alternate; a stopped lane shows the inverse so stale values never match
   always_ff @(posedge hclk)
   begin
      for (int i = 0; i < LANES; i++)
      begin
         lane_hdr[i] <= !run ? ~lane_hdr[i] : (i == 0 && bad) ? 2'h3 :
            (lane_hdr[i] === SYNC_DATA) ? SYNC_CTRL : SYNC_DATA; // unknown start gives data
         lane_hdr_valid[i] <= run;
      end
   end
endmodule : link_partner_model

`default_nettype wire

// File: bench/testbench.sv
/*
 Self-checking bench for the link path control and status block.
 Assumes the package, the design and the partner model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import link_ctl_pkg::*;

   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, bad;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic tx_in_valid, tx_in_ready, rx_in_valid, rx_out_valid, tx_local_fault;
   beat_t tx_in, rx_in, rx_out;
   code_word_t tx_out;
   logic [LANES-1:0][1:0] lane_hdr;
   logic [LANES-1:0] lane_hdr_valid;
   lane_stat_t [LANES-1:0] lane_stat;
   int err_total, num_checks, cyc, nb;

   link_path_control_status u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_in_valid,
      .tx_in, .tx_in_ready, .tx_out, .lane_hdr, .lane_hdr_valid, .rx_in_valid, .rx_in,
      .rx_out_valid, .rx_out, .lane_stat, .tx_local_fault);
   link_partner_model u_far (.hclk, .run, .bad, .lane_hdr, .lane_hdr_valid);

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task print_verdict;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // hang guard, well above the few hundred cycles the sequence needs
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         print_verdict();
      end
   end

   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // one single word transfer; on a read d is the expected word
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk(hresp, HRESP_OKAY);
      if (!w)
         chk(hrdata, d);
   endtask : bus

   function automatic beat_t rb(input logic s, input logic e);
      rb = {s, e, 1'b0, $urandom, $urandom};
   endfunction : rb

   function automatic code_kind_t fk(input logic [2:0] f);
      fk = f[0] ? CW_LFAULT : f[1] ? CW_RFAULT : f[2] ? CW_IDLE : CW_DATA;
   endfunction : fk

   task automatic tx(input beat_t b, input logic rdy, input code_kind_t k);
      @(posedge hclk);
      tx_in_valid <= 1'b1;
      tx_in <= b;
      @(posedge hclk);
      chk(tx_in_ready, rdy);
      tx_in_valid <= 1'b0;
      @(posedge hclk);
      chk(tx_out, {k, (k == CW_DATA) ? b : beat_t'(0)});
   endtask : tx

   task automatic rx(input beat_t b, input logic pass);
      @(posedge hclk);
      rx_in_valid <= 1'b1;
      rx_in <= b;
      @(posedge hclk);
      rx_in_valid <= 1'b0;
      rx_in <= ~b;
      @(posedge hclk);
      chk({rx_out_valid, rx_out}, pass ? {1'b1, b} : 68'h0);
   endtask : rx

   task automatic wait_stat;
      for (int i = 0; i < 40 && lane_stat[0].valid !== 1'b1; i++)
         @(posedge hclk);
   endtask : wait_stat

   initial
   begin
      void'($urandom(32'hDE105FD3));
      {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, run, bad} = '0;
      {tx_in_valid, tx_in, rx_in_valid, rx_in} = '0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk({tx_local_fault, tx_out.kind}, {1'b1, CW_IDLE});
      bus(0, OFS_CTRL, 32'h0);
      bus(1, 8'h40, 32'hFFFFFFFF);
      bus(0, 8'h40, 32'h0);
      run <= 1'b1;
      tx(rb(1, 1), 0, CW_IDLE);
      repeat (80) @(posedge hclk);
      chk(tx_local_fault, 1'b1);
      bus(0, OFS_LOCK, 32'h0);
      bus(1, OFS_CTRL, 32'h14);
      tx(rb(1, 1), 0, CW_RFAULT);
      repeat (80) @(posedge hclk);
      chk(tx_local_fault, 1'b0);
      bus(0, OFS_STATUS, 32'h8);
      bus(0, OFS_LOCK, 32'hFFFFF);
      for (int f = 0; f < 8; f++)
      begin
         bus(1, OFS_CTRL, 32'h11 | (32'(f) << 1));
         tx(rb(1, 1), f == 0, fk(f[2:0]));
      end
      // drop transmit enable with a packet open
      bus(1, OFS_CTRL, 32'h11);
      tx(rb(1, 0), 1, CW_DATA);
      bus(1, OFS_CTRL, 32'h10);
      bus(0, OFS_STATUS, 32'hA);
      tx(rb(0, 0), 1, CW_DATA);
      tx(rb(0, 1), 1, CW_DATA);
      tx(rb(1, 1), 0, CW_IDLE);
      // drop receive enable with a packet open
      rx(rb(1, 1), 1);
      rx(rb(1, 0), 1);
      bus(1, OFS_CTRL, 32'h0);
      bus(0, OFS_STATUS, 32'hC);
      rx(rb(0, 1), 1);
      rx(rb(1, 1), 0);
      bus(1, OFS_CTRL, 32'h10);
      // broken headers on lane 0 inside one window, all clean elsewhere
      for (int n = 0; n < 5; n++)
      begin
         nb = (n == 0) ? 7 : (n == 1) ? 0 : $urandom_range(7, 0);
         wait_stat();
         repeat (3) @(posedge hclk);
         repeat (nb)
         begin
            bad <= 1'b1;
            @(posedge hclk);
         end
         bad <= 1'b0;
         @(posedge hclk);
         wait_stat();
         chk(lane_stat[0].count, nb[3:0]);
         chk(lane_stat[1], {1'b1, 4'h0});
      end
      bus(1, OFS_CTRL, 32'h30);
      rx(rb(1, 1), 0);
      chk(tx_local_fault, 1'b1);
      bus(1, OFS_CTRL, 32'h10);
      repeat (90) @(posedge hclk);
      chk(tx_local_fault, 1'b0);
      rx(rb(1, 1), 1);
      // two whole packets went out, three came in
      bus(0, OFS_TX_PKTS, 32'h2);
      bus(0, OFS_RX_PKTS, 32'h3);
      print_verdict();
   end
endmodule : testbench

`default_nettype wire
